// ===== hdl/uwl_pkg.sv
package uwl_pkg;

    // ========
    // Timing counts
    // System clocks per 16x sample tick; no baud rate is fixed here
    localparam int BAUD_DIV_DEFAULT = 4;
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;

    // ========
    // Frame sizes in bit times
    localparam logic [3:0] CHAR_BITS_8 = 4'hA;
    localparam logic [3:0] CHAR_BITS_9 = 4'hB;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;

    // ========
    // Reset values
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic TX_DONE_RST = 1'b1;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic QUIET_ARMED_RST = 1'b1;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uwl_rx_state_t;

    // ========
    // Shared arithmetic
    function automatic logic uwlMajority(input logic [2:0] s);
        uwlMajority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Parity over the data bits below the MSB position
    function automatic logic uwlParity(input logic [8:0] w, input logic nine,
                                       input logic odd);
        uwlParity = (nine ? ^w[7:0] : ^w[6:0]) ^ odd;
    endfunction

endpackage

// ===== hdl/uwl_pin_sync.sv
module uwl_pin_sync
    import uwl_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic pinLevel
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } uwl_sync_t;

    uwl_sync_t sync_reg;
    uwl_sync_t sync_next;

    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = pinIn;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        // Change accepted only when the last two stages agree
        if (sync_reg.s2 == sync_reg.s3) begin
            sync_next.level = sync_reg.s3;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_reg <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL,
                          level: RESET_LEVEL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign pinLevel = sync_reg.level;

endmodule

// ===== hdl/uwl_core.sv
// Function
// - Wake select 0: idle line of 10 or 11 bit times clears receiver sleep.
// - The waking idle character sets neither line-quiet nor receive-full.
// - Quiet count start 0 counts after start bit; 1 only after stop bit.
// - Wake select 1: character with MSB one clears receiver sleep.
// - Address frame clears sleep before its stop bit and sets receive-full.
// - Three interrupt requests: transmit, receive and error groups.
// - Eight sources each have an enable; flags stay readable when masked.
// - Transmit-empty shows buffer room; interrupt requested while flag and enable.
// - Transmit-done set when everything sent and pin idles high.
// - Receive-full clears by status read while set, then data read.
// - Line-quiet clears by same sequence; rearms only after a new character.
// - Noise, framing, parity flags set with receive-full; never on overrun.
// - Character arriving while receive-full is set sets overrun, data lost.
// - Nine-bit mode adds ninth bit both ways, held in own bits.
// - Transmit ninth bit copied into shifter with data; it persists.
// - Stop modes halt the block; deep ones lose state, light keeps it.
// - Loop mode routes transmitter to receiver and releases receive pin.
// - Single-wire mode: receiver hears transmitter (direction 1) or transmit pin (direction 0); rx pin released.
// - Single-wire direction 0 makes transmit pin input; 1 drives it.
// - Single-wire direction 1: receiver hears every character transmitted.
// - Receiver sleep suppresses all receiver flags; software sets it by writing 1.
module uwl_core
    import uwl_pkg::*;
#(
    parameter int BAUD_DIV = BAUD_DIV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rxPin,
    input wire logic txPinIn,
    output logic txPinOut,
    output logic txPinOe,
    output logic rxPinReleased,
    input wire logic txEnable,
    input wire logic rxEnable,
    input wire logic ninthBitMode,
    input wire logic wakeSelect,
    input wire logic quietCountStartSelect,
    input wire logic parityEn,
    input wire logic parityOdd,
    input wire logic internalLoopEn,
    input wire logic rxSourceSelect,
    input wire logic pinDriveDirection,
    input wire logic txNinthBit,
    input wire logic txEmptyIrqEn,
    input wire logic txDoneIrqEn,
    input wire logic rxFullIrqEn,
    input wire logic quietIrqEn,
    input wire logic overrunIrqEn,
    input wire logic noiseIrqEn,
    input wire logic framingIrqEn,
    input wire logic parityIrqEn,
    input wire logic dataWrite,
    input wire logic [7:0] writeData,
    input wire logic statusRead,
    input wire logic dataRead,
    input wire logic sleepWrite,
    input wire logic sleepWriteValue,
    input wire logic stopDeep,
    input wire logic stopLight,
    output logic [7:0] readData,
    output logic rxNinthBit,
    output logic receiverSleep,
    output logic txBufferEmpty,
    output logic txDoneFlag,
    output logic rxBufferFull,
    output logic lineQuietFlag,
    output logic overrunFlag,
    output logic noiseFlag,
    output logic framingErrorFlag,
    output logic parityErrorFlag,
    output logic txIrq,
    output logic rxIrq,
    output logic errIrq
);

    // ========
    // State
    typedef struct packed {
        logic [15:0] baudCnt;
        logic [7:0] txBufData;
        logic txEmpty;
        logic [10:0] txShift;
        logic [3:0] txLeft;
        logic [3:0] txSub;
        logic txBusy;
        logic txLine;
        logic txDone;
        logic txOe;
        uwl_rx_state_t rxState;
        logic [3:0] rxSub;
        logic [3:0] rxBit;
        logic [8:0] rxShift;
        logic [1:0] rxSamp;
        logic rxNoise;
        logic [3:0] idleCnt;
        logic idleCountOn;
        logic idleArmed;
        logic [7:0] rxData;
        logic rxNinth;
        logic rx_buffer_full;
        logic quiet;
        logic ovr;
        logic nf;
        logic fe;
        logic pf;
        logic armRdrf;
        logic armQuiet;
        logic armErr;
        logic sleep;
        logic irqTx;
        logic irqRx;
        logic irqErr;
        logic rxReleased;
    } uwl_state_t;

    localparam uwl_state_t RESET_STATE = '{txEmpty: TX_EMPTY_RST, txDone: TX_DONE_RST,
                                          txLine: LINE_IDLE, rxState: RX_IDLE,
                                          idleArmed: QUIET_ARMED_RST, idleCountOn: 1'b1,
                                          default: '0};

    uwl_state_t state_reg;
    uwl_state_t state_next;
    logic rxPinSync;
    logic txPinSync;

    uwl_pin_sync #(.RESET_LEVEL(LINE_IDLE)) rxSyncInst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pinIn(rxPin),
        .pinLevel(rxPinSync)
    );

    uwl_pin_sync #(.RESET_LEVEL(LINE_IDLE)) txSyncInst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pinIn(txPinIn),
        .pinLevel(txPinSync)
    );

    // ========
    // Next state
    always_comb begin
        uwl_state_t n;
        logic tick;
        logic rxIn;
        logic [3:0] charBits;
        logic [3:0] dataBits;
        logic [2:0] samples;
        logic bitVal;
        logic countOne;
        logic countZero;
        logic idleHit;
        logic charDone;
        logic [8:0] word;
        n = state_reg;
        tick = state_reg.baudCnt == 16'(BAUD_DIV - 1);
        rxIn = rxPinSync;
        charBits = ninthBitMode ? CHAR_BITS_9 : CHAR_BITS_8;
        dataBits = ninthBitMode ? DATA_BITS_9 : DATA_BITS_8;
        samples = {state_reg.rxSamp, rxIn};
        bitVal = 1'b0;
        countOne = 1'b0;
        countZero = 1'b0;
        idleHit = 1'b0;
        charDone = 1'b0;
        word = '0;
        n.baudCnt = tick ? 16'h0000 : state_reg.baudCnt + 16'h0001;

        // Receiver source selection
        if (internalLoopEn) begin
            if (rxSourceSelect && !pinDriveDirection) begin
                rxIn = txPinSync;
            end else begin
                rxIn = state_reg.txLine;
            end
            samples = {state_reg.rxSamp, rxIn};
        end
        n.rxReleased = internalLoopEn;

        // Two-step flag clearing; sets further down win the cycle
        if (dataRead) begin
            if (state_reg.armRdrf) begin
                n.rx_buffer_full = 1'b0;
            end
            if (state_reg.armQuiet) begin
                n.quiet = 1'b0;
            end
            if (state_reg.armErr) begin
                n.ovr = 1'b0;
                n.nf = 1'b0;
                n.fe = 1'b0;
                n.pf = 1'b0;
            end
            n.armRdrf = 1'b0;
            n.armQuiet = 1'b0;
            n.armErr = 1'b0;
        end
        if (statusRead) begin
            n.armRdrf = state_reg.rx_buffer_full;
            n.armQuiet = state_reg.quiet;
            n.armErr = state_reg.ovr | state_reg.nf | state_reg.fe | state_reg.pf;
        end

        // ========
        // Transmitter
        // Writes while the buffer is full are dropped
        if (dataWrite && state_reg.txEmpty) begin
            n.txBufData = writeData;
            n.txEmpty = 1'b0;
            n.txDone = 1'b0;
        end
        if (tick) begin
            if (state_reg.txBusy) begin
                if (state_reg.txSub == SUB_LAST) begin
                    n.txSub = 4'h0;
                    n.txShift = {1'b1, state_reg.txShift[10:1]};
                    n.txLine = state_reg.txShift[1];
                    n.txLeft = state_reg.txLeft - 4'h1;
                    if (state_reg.txLeft == 4'h1) begin
                        n.txBusy = 1'b0;
                        n.txLine = LINE_IDLE;
                        n.txDone = n.txEmpty;
                    end
                end else begin
                    n.txSub = state_reg.txSub + 4'h1;
                end
            end else if (!state_reg.txEmpty && txEnable) begin
                word = {txNinthBit, state_reg.txBufData};
                if (parityEn) begin
                    if (ninthBitMode) begin
                        word[8] = uwlParity(word, 1'b1, parityOdd);
                    end else begin
                        word[7] = uwlParity(word, 1'b0, parityOdd);
                    end
                end
                n.txShift = ninthBitMode ? {1'b1, word, 1'b0}
                                         : {2'b11, word[7:0], 1'b0};
                n.txLeft = charBits;
                n.txSub = 4'h0;
                n.txBusy = 1'b1;
                n.txLine = 1'b0;
                n.txEmpty = 1'b1;
            end
        end
        // Single-wire input direction lets the far end drive the pin
        n.txOe = (txEnable | n.txBusy) &
                 ~(internalLoopEn & rxSourceSelect & ~pinDriveDirection);

        // ========
        // Receiver
        if (!rxEnable) begin
            n.rxState = RX_IDLE;
            n.rxSub = 4'h0;
        end else if (tick) begin
            bitVal = uwlMajority(samples);
            case (state_reg.rxState)
                RX_IDLE: begin
                    n.idleCountOn = 1'b1;
                    if (!rxIn) begin
                        n.rxState = RX_START;
                        n.rxSub = 4'h0;
                        n.rxNoise = 1'b0;
                        n.idleCnt = 4'h0;
                        n.idleCountOn = !quietCountStartSelect;
                    end else begin
                        n.rxSub = state_reg.rxSub + 4'h1;
                        countOne = state_reg.rxSub == SUB_LAST;
                    end
                end
                RX_START, RX_DATA, RX_STOP: begin
                    n.rxSub = state_reg.rxSub + 4'h1;
                    if (state_reg.rxSub == SAMPLE_A || state_reg.rxSub == SAMPLE_B) begin
                        n.rxSamp = samples[1:0];
                    end
                    if (state_reg.rxSub == SAMPLE_C) begin
                        if (samples != 3'b000 && samples != 3'b111) begin
                            n.rxNoise = 1'b1;
                        end
                        if (state_reg.rxState == RX_START) begin
                            if (bitVal) begin
                                n.rxState = RX_IDLE; // False start, back to hunting
                            end
                        end else begin
                            countOne = bitVal & state_reg.idleCountOn;
                            countZero = ~bitVal;
                        end
                        if (state_reg.rxState == RX_DATA) begin
                            n.rxShift = {bitVal, state_reg.rxShift[8:1]};
                            if (state_reg.rxBit == dataBits - 4'h1 && bitVal &&
                                state_reg.sleep && wakeSelect) begin
                                n.sleep = 1'b0;
                            end
                        end
                        if (state_reg.rxState == RX_STOP) begin
                            charDone = 1'b1;
                            n.rxState = RX_IDLE;
                            n.rxSub = 4'h0;
                            if (quietCountStartSelect) begin
                                n.idleCnt = 4'h0;
                            end
                        end
                    end
                    if (state_reg.rxSub == SUB_LAST) begin
                        n.rxSub = 4'h0;
                        if (state_reg.rxState == RX_START) begin
                            n.rxState = RX_DATA;
                            n.rxBit = 4'h0;
                        end else if (state_reg.rxState == RX_DATA) begin
                            n.rxBit = state_reg.rxBit + 4'h1;
                            if (state_reg.rxBit == dataBits - 4'h1) begin
                                n.rxState = RX_STOP;
                            end
                        end
                    end
                end
                default: begin
                    n.rxState = RX_IDLE;
                end
            endcase
        end

        // Idle-line counting, saturating at one character time
        if (countZero) begin
            n.idleCnt = 4'h0;
        end else if (countOne && state_reg.idleCnt != charBits) begin
            n.idleCnt = state_reg.idleCnt + 4'h1;
            idleHit = (state_reg.idleCnt + 4'h1) == charBits;
        end

        if (idleHit) begin
            if (state_reg.sleep && !wakeSelect) begin
                n.sleep = 1'b0;
            end else if (!state_reg.sleep && state_reg.idleArmed) begin
                n.quiet = 1'b1;
                n.idleArmed = 1'b0;
            end
        end

        if (charDone && !state_reg.sleep) begin
            word = ninthBitMode ? n.rxShift : {1'b0, n.rxShift[8:1]};
            if (state_reg.rx_buffer_full) begin
                n.ovr = 1'b1;
            end else begin
                n.rxData = word[7:0];
                n.rxNinth = word[8];
                n.rx_buffer_full = 1'b1;
                n.idleArmed = 1'b1;
                n.nf = state_reg.nf | state_reg.rxNoise | n.rxNoise;
                n.fe = state_reg.fe | ~bitVal;
                n.pf = state_reg.pf | (parityEn &
                       (uwlParity(word, ninthBitMode, parityOdd) !=
                        (ninthBitMode ? word[8] : word[7])));
            end
        end

        // Software write wins over a hardware wake in the same cycle
        if (sleepWrite) begin
            n.sleep = sleepWriteValue;
        end

        // ========
        // Interrupt requests
        n.irqTx = (n.txEmpty & txEmptyIrqEn) | (n.txDone & txDoneIrqEn);
        n.irqRx = (n.rx_buffer_full & rxFullIrqEn) | (n.quiet & quietIrqEn);
        n.irqErr = (n.ovr & overrunIrqEn) | (n.nf & noiseIrqEn) |
                   (n.fe & framingIrqEn) | (n.pf & parityIrqEn);

        // Stop modes: deep ones lose everything, the light one freezes
        if (stopDeep) begin
            n = RESET_STATE;
        end else if (stopLight) begin
            n = state_reg;
        end
        state_next = n;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========
    // Outputs
    assign txPinOut = state_reg.txLine;
    assign txPinOe = state_reg.txOe;
    assign rxPinReleased = state_reg.rxReleased;
    assign readData = state_reg.rxData;
    assign rxNinthBit = state_reg.rxNinth;
    assign receiverSleep = state_reg.sleep;
    assign txBufferEmpty = state_reg.txEmpty;
    assign txDoneFlag = state_reg.txDone;
    assign rxBufferFull = state_reg.rx_buffer_full;
    assign lineQuietFlag = state_reg.quiet;
    assign overrunFlag = state_reg.ovr;
    assign noiseFlag = state_reg.nf;
    assign framingErrorFlag = state_reg.fe;
    assign parityErrorFlag = state_reg.pf;
    assign txIrq = state_reg.irqTx;
    assign rxIrq = state_reg.irqRx;
    assign errIrq = state_reg.irqErr;

endmodule

// ===== bench/uwl_checker.sv
module uwl_checker #(
    parameter int BAUD_DIV = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stopDeep,
    input wire logic stopLight,
    input wire logic txEmptyIrqEn,
    input wire logic txDoneIrqEn,
    input wire logic rxFullIrqEn,
    input wire logic quietIrqEn,
    input wire logic dataWrite,
    input wire logic dataRead,
    input wire logic internalLoopEn,
    input wire logic rxSourceSelect,
    input wire logic pinDriveDirection,
    input wire logic txPinOut,
    input wire logic txPinOe,
    input wire logic rxPinReleased,
    input wire logic [7:0] readData,
    input wire logic receiverSleep,
    input wire logic txBufferEmpty,
    input wire logic txDoneFlag,
    input wire logic rxBufferFull,
    input wire logic lineQuietFlag,
    input wire logic overrunFlag,
    input wire logic noiseFlag,
    input wire logic framingErrorFlag,
    input wire logic parityErrorFlag,
    input wire logic txIrq,
    input wire logic rxIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // Helper
    // Stop modes and reset move flags: skip their edges and the one after
    logic steady_reg;
    always_ff @(posedge sys_clk) steady_reg <= rst_n && !stopDeep && !stopLight;
    wire logic steady = steady_reg && !stopDeep && !stopLight;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ========
    // Properties
    a_tx_irq_group: assert property (steady |-> txIrq == (txBufferEmpty && $past(txEmptyIrqEn)
        || txDoneFlag && $past(txDoneIrqEn))) else $error("transmit request wrong");
    a_rx_irq_group: assert property (steady |-> rxIrq == (rxBufferFull && $past(rxFullIrqEn)
        || lineQuietFlag && $past(quietIrqEn))) else $error("receive request wrong");
    a_full_clear: assert property (steady && $fell(rxBufferFull) |-> $past(dataRead))
        else $error("receive full cleared without data read");
    a_err_with_full: assert property (steady && $rose(noiseFlag || framingErrorFlag
        || parityErrorFlag) |-> $rose(rxBufferFull)) else $error("error flag apart from full");
    a_overrun_keep: assert property (steady && $rose(overrunFlag) |->
        $past(rxBufferFull) && $stable(readData)) else $error("overrun handling wrong");
    a_sleep_quiet: assert property (steady && $rose(rxBufferFull || lineQuietFlag) |->
        !$past(receiverSleep)) else $error("flag set while asleep");
    a_done_idle: assert property (txDoneFlag |-> txPinOut)
        else $error("done while line low");
    a_pin_release: assert property (steady |-> rxPinReleased == $past(internalLoopEn))
        else $error("receive pin release wrong");
    a_wire_input: assert property (steady && $past(internalLoopEn && rxSourceSelect
        && !pinDriveDirection) |-> !txPinOe) else $error("transmit pin driven as input");
    a_tx_refill: assert property (steady && $fell(txBufferEmpty) |-> $past(dataWrite))
        else $error("empty flag fell without write");
endmodule

// ===== bench/uwl_remote_node.sv
module uwl_remote_node #(
    parameter int BIT_CLKS = 16
) (
    input wire logic sys_clk,
    input wire logic txLine,
    input wire logic nineMode,
    output logic rxLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] heard = 9'h000;
    // ========
    // Sender: start, data LSB first, stop; released line idles high
    initial rxLine = 1'h1;
    task automatic send(input logic [8:0] w, input logic nine, input logic stopBit);
        logic [10:0] f;
        f = nine ? {stopBit, w, 1'h0} : {1'h1, stopBit, w[7:0], 1'h0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            @(posedge sys_clk);
            rxLine <= f[i];
            repeat (BIT_CLKS - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        rxLine <= 1'h1;
    endtask
    // ========
    // Listener: mid-bit sampling of the transmit wire
    initial begin
        logic [8:0] w;
        forever begin
            @(negedge txLine);
            w = 9'h000;
            repeat (BIT_CLKS / 2) @(posedge sys_clk);
            for (int i = 0; i < 9; i++) begin
                if (i < 8 || nineMode) begin
                    repeat (BIT_CLKS) @(posedge sys_clk);
                    w[i] = txLine;
                end
            end
            repeat (BIT_CLKS) @(posedge sys_clk);
            heard = w;
        end
    end
endmodule

// ===== bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 16;
    localparam int LIMIT = 20000;
    logic sys_clk, rst_n, txEnable, rxEnable, ninthBitMode, wakeSelect, quietCountStartSelect;
    logic parityEn, parityOdd, internalLoopEn, rxSourceSelect, pinDriveDirection, txNinthBit;
    logic txEmptyIrqEn, txDoneIrqEn, rxFullIrqEn, quietIrqEn, overrunIrqEn, noiseIrqEn;
    logic framingIrqEn, parityIrqEn, dataWrite, statusRead, dataRead, sleepWrite;
    logic sleepWriteValue, stopDeep, stopLight, txPinOut, txPinOe, rxPinReleased, rxNinthBit;
    logic receiverSleep, txBufferEmpty, txDoneFlag, rxBufferFull, lineQuietFlag, overrunFlag;
    logic noiseFlag, framingErrorFlag, parityErrorFlag, txIrq, rxIrq, errIrq, remoteLine;
    logic [7:0] writeData, readData;
    logic txWire;
    int errCount = 0;
    int nCompared = 0;
    int cycles = 0;
    // Shared wire: the remote end only reaches it while the block lets go
    assign txWire = txPinOe ? txPinOut : remoteLine;
    uwl_core #(.BAUD_DIV(1)) uwl_core_i (.*, .rxPin(remoteLine), .txPinIn(txWire));
    uwl_remote_node #(.BIT_CLKS(BIT)) uwl_remote_node_i (.sys_clk(sys_clk), .txLine(txWire),
        .nineMode(ninthBitMode), .rxLine(remoteLine));
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ========
    // Access tasks
    task step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task check(input logic [8:0] seen, input logic [8:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] d);
        @(posedge sys_clk);
        dataWrite <= 1'h1;
        writeData <= d;
        @(posedge sys_clk);
        dataWrite <= 1'h0;
    endtask
    task rdclr(input logic st);
        @(posedge sys_clk);
        statusRead <= st;
        @(posedge sys_clk);
        statusRead <= 1'h0;
        dataRead <= 1'h1;
        @(posedge sys_clk);
        dataRead <= 1'h0;
        step(2);
    endtask
    task rx(input logic [8:0] w, input logic nine, input logic stopBit);
        uwl_remote_node_i.send(w, nine, stopBit);
        step(4);
    endtask
    task sleepOn;
        @(posedge sys_clk);
        sleepWrite <= 1'h1;
        sleepWriteValue <= 1'h1;
        @(posedge sys_clk);
        sleepWrite <= 1'h0;
        step(2);
        check(receiverSleep, 1'h1);
    endtask
    task complete_run;
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errCount++;
            complete_run();
        end
    end
    // ========
    // Sequence
    initial begin
        {rst_n, ninthBitMode, wakeSelect, quietCountStartSelect, parityEn, parityOdd} = '0;
        {internalLoopEn, rxSourceSelect, pinDriveDirection, txNinthBit, dataWrite} = '0;
        {statusRead, dataRead, sleepWrite, sleepWriteValue, stopDeep, stopLight} = '0;
        {txEnable, rxEnable, txEmptyIrqEn, txDoneIrqEn, rxFullIrqEn, quietIrqEn} = '1;
        {overrunIrqEn, noiseIrqEn, framingIrqEn, parityIrqEn} = '1;
        writeData = 8'h00;
        step(8);
        rst_n <= 1'h1;
        step(3);
        check(txBufferEmpty, 1'h1);
        check(txDoneFlag, 1'h1);
        check(txIrq, 1'h1);
        {ninthBitMode, txNinthBit, txEmptyIrqEn, txDoneIrqEn} <= 4'hC;
        wr(8'h5A);
        step(13 * BIT);
        check(uwl_remote_node_i.heard, 9'h15A);
        check(txDoneFlag, 1'h1);
        check(txIrq, 1'h0);
        txEmptyIrqEn <= 1'h1;
        wr(8'h33);
        step(13 * BIT);
        check(uwl_remote_node_i.heard, 9'h133);
        check(txIrq, 1'h1);
        rx(9'h1C3, 1'h1, 1'h1);
        check(readData, 8'hC3);
        check(rxNinthBit, 1'h1);
        rdclr(1'h1);
        ninthBitMode <= 1'h0;
        rx(9'h096, 1'h0, 1'h1);
        check(rxIrq, 1'h1);
        rdclr(1'h0);
        check(rxBufferFull, 1'h1);
        step(12 * BIT);
        check(lineQuietFlag, 1'h1);
        rdclr(1'h1);
        check(rxBufferFull, 1'h0);
        step(24 * BIT);
        check(lineQuietFlag, 1'h0);
        {overrunIrqEn, noiseIrqEn, framingIrqEn, parityIrqEn} <= 4'h0;
        rx(9'h011, 1'h0, 1'h1);
        rx(9'h022, 1'h0, 1'h0);
        check({overrunFlag, framingErrorFlag, errIrq}, 9'h004);
        check(readData, 8'h11);
        {overrunIrqEn, noiseIrqEn, framingIrqEn, parityIrqEn} <= 4'hF;
        step(2);
        check(errIrq, 1'h1);
        rdclr(1'h1);
        rx(9'h044, 1'h0, 1'h0);
        check({framingErrorFlag, rxBufferFull, overrunFlag}, 9'h006);
        rdclr(1'h1);
        parityEn <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            parityOdd <= k[0];
            rx(9'h001, 1'h0, 1'h1);
            check(parityErrorFlag, k == 0);
            rdclr(1'h1);
        end
        parityEn <= 1'h0;
        for (int k = 0; k < 2; k++) begin
            quietCountStartSelect <= k[0];
            rx(9'h000, 1'h0, 1'h1);
            rdclr(1'h1);
            sleepOn();
            rx(9'h0FF, 1'h0, 1'h1);
            step(4 * BIT);
            check({receiverSleep, lineQuietFlag}, {k[0], 1'h0});
            step(9 * BIT);
            check({receiverSleep, rxBufferFull}, 9'h000);
        end
        wakeSelect <= 1'h1;
        sleepOn();
        rx(9'h005, 1'h0, 1'h1);
        check({receiverSleep, rxBufferFull}, 9'h002);
        rx(9'h085, 1'h0, 1'h1);
        check({receiverSleep, rxBufferFull, readData}, 9'h185);
        rdclr(1'h1);
        {wakeSelect, internalLoopEn} <= 2'h1;
        step(2);
        check(rxPinReleased, 1'h1);
        wr(8'h3C);
        step(12 * BIT);
        check(readData, 8'h3C);
        rdclr(1'h1);
        {rxSourceSelect, pinDriveDirection} <= 2'h3;
        wr(8'hA7);
        step(12 * BIT);
        check({rxBufferFull, readData}, 9'h1A7);
        check(uwl_remote_node_i.heard, 9'h0A7);
        rdclr(1'h1);
        pinDriveDirection <= 1'h0;
        step(2);
        check(txPinOe, 1'h0);
        rx(9'h06B, 1'h0, 1'h1);
        check(readData, 8'h6B);
        rdclr(1'h1);
        {internalLoopEn, rxSourceSelect} <= 2'h0;
        rx(9'h012, 1'h0, 1'h1);
        stopLight <= 1'h1;
        step(6);
        stopLight <= 1'h0;
        step(2);
        check({rxBufferFull, readData}, 9'h112);
        stopDeep <= 1'h1;
        step(2);
        stopDeep <= 1'h0;
        step(2);
        check({rxBufferFull, txBufferEmpty}, 9'h001);
        complete_run();
    end
endmodule
bind uwl_core uwl_checker #(.BAUD_DIV(BAUD_DIV)) uwl_checker_i (.*);
